// file: hdl/prab_pkg.sv
// Shared constants and types for the peripheral register access bridge
package prab_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int BUS_W = 3;
  localparam int RATIO_W = 3;
  localparam int CNT_W = 8;
  localparam int SYNC_W = 4;
  // Peripheral bus numbers; external bus control sits on its own code
  localparam logic [BUS_W-1:0] BUS_P1 = 3'h1;
  localparam logic [BUS_W-1:0] BUS_P2 = 3'h2;
  localparam logic [BUS_W-1:0] BUS_P4 = 3'h4;
  localparam logic [BUS_W-1:0] BUS_P5 = 3'h5;
  localparam logic [BUS_W-1:0] BUS_P6 = 3'h6;
  localparam logic [BUS_W-1:0] BUS_EXT = 3'h7;
  localparam logic [CNT_W-1:0] MAIN_CYCLES = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [SYNC_W-1:0] SYNC_ONE = 4'h1;
  localparam logic [RATIO_W-1:0] RATIO_ZERO = 3'h0;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 3'h1;

  typedef enum logic [5:0] {
    PRAB_IDLE = 6'h01,
    PRAB_MAIN = 6'h02,
    PRAB_SYNC = 6'h04,
    PRAB_PER  = 6'h08,
    PRAB_WAIT = 6'h10,
    PRAB_DONE = 6'h20
  } prab_state_t;
endpackage

// file: hdl/prab_pdiv.sv
// Peripheral clock phase generator derived from the core clock
`timescale 1ns/10ps
module prab_pdiv
  import prab_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic [RATIO_W-1:0] ratio, // Core cycles per peripheral cycle, minus one
  output logic tick // High in the last core cycle of each peripheral cycle
);
  logic [RATIO_W-1:0] phase;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= RATIO_ZERO;
    end else if (phase >= ratio) begin
      phase <= RATIO_ZERO;
    end else begin
      phase <= phase + RATIO_ONE;
    end
  end

  // A ratio lowered mid-count wraps at once rather than running past it
  assign tick = (phase >= ratio);
endmodule

// file: hdl/prab_bridge.sv
// Bridge from the core main bus to the divided-clock peripheral buses
`timescale 1ns/10ps
module prab_bridge
  import prab_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic [RATIO_W-1:0] pclk_ratio, // Core cycles per peripheral cycle, minus one
  input wire logic cpu_req, // CPU access request, level
  input wire logic cpu_we, // Write when high
  input wire logic [ADDR_W-1:0] cpu_addr, // Register address
  input wire logic [DATA_W-1:0] cpu_wdata, // Write data
  input wire logic [BUS_W-1:0] cpu_bus, // Peripheral bus holding the register
  input wire logic cpu_berr_reg, // Target is a bus-error register
  input wire logic dtc_busy, // Transfer controller owns the bus
  output logic cpu_ready, // Access complete, one-cycle pulse
  output logic [DATA_W-1:0] cpu_rdata, // Read data
  output logic cpu_stall, // Access in progress
  output logic [CNT_W-1:0] acc_cycles, // Cycle count of the last access
  output logic per_req, // Peripheral strobe, one cycle
  output logic per_we, // Peripheral write
  output logic [ADDR_W-1:0] per_addr, // Peripheral address
  output logic [DATA_W-1:0] per_wdata, // Peripheral write data
  output logic [BUS_W-1:0] per_bus, // Peripheral bus select
  input wire logic per_ack, // Peripheral access done
  input wire logic [DATA_W-1:0] per_rdata // Peripheral read data
);
  prab_state_t state;
  prab_state_t next_state;
  logic need_sync;
  logic tick;
  logic [SYNC_W-1:0] sync_cnt;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] elapsed;
  logic acked;

  function automatic logic sync_bus(input logic [BUS_W-1:0] bus, input logic berr);
    case (bus)
      BUS_P2, BUS_P4, BUS_P5, BUS_P6: sync_bus = 1'b1;
      BUS_EXT: sync_bus = !berr;
      default: sync_bus = 1'b0;
    endcase
  endfunction

  prab_pdiv u_pdiv (
    .clk(clk),
    .resetn(resetn),
    .ratio(pclk_ratio),
    .tick(tick)
  );

  assign acked = per_ack && (state == PRAB_PER || state == PRAB_WAIT);

  always_comb begin
    next_state = state;
    case (state)
      PRAB_IDLE: begin
        if (cpu_req && !dtc_busy) begin
          next_state = PRAB_MAIN;
        end
      end
      PRAB_MAIN: begin
        // A bus needing no sync, or a boundary in the main cycle, needs no wait; otherwise sync to next
        if (!need_sync || tick) begin
          next_state = PRAB_PER;
        end else begin
          next_state = PRAB_SYNC;
        end
      end
      PRAB_SYNC: begin
        if (tick) begin
          next_state = PRAB_PER;
        end
      end
      PRAB_PER, PRAB_WAIT: begin
        next_state = acked ? PRAB_DONE : PRAB_WAIT;
      end
      PRAB_DONE: next_state = PRAB_IDLE;
      default: next_state = PRAB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= PRAB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request is latched at acceptance so the CPU may change its pins afterwards
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_we <= 1'b0;
      per_addr <= '0;
      per_wdata <= '0;
      per_bus <= '0;
      need_sync <= 1'b0;
    end else if (state == PRAB_IDLE && cpu_req && !dtc_busy) begin
      per_we <= cpu_we;
      per_addr <= cpu_addr;
      per_wdata <= cpu_wdata;
      per_bus <= cpu_bus;
      need_sync <= sync_bus(cpu_bus, cpu_berr_reg);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_cnt <= '0;
      per_cnt <= '0;
    end else if (state == PRAB_MAIN) begin
      sync_cnt <= '0;
      per_cnt <= '0;
    end else if (state == PRAB_SYNC) begin
      sync_cnt <= sync_cnt + SYNC_ONE;
    end else if (state == PRAB_PER || state == PRAB_WAIT) begin
      per_cnt <= per_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_cycles <= '0;
      cpu_rdata <= '0;
    end else if (acked) begin
      // Sum counts the finishing peripheral cycle too
      acc_cycles <= MAIN_CYCLES + CNT_W'(sync_cnt) + per_cnt + CNT_ONE;
      cpu_rdata <= per_we ? '0 : per_rdata;
    end
  end

  // Independent stopwatch used only to check the reported count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      elapsed <= '0;
    end else if (state == PRAB_IDLE) begin
      elapsed <= '0;
    end else if (state != PRAB_DONE) begin
      elapsed <= elapsed + CNT_ONE;
    end
  end

  assign per_req = (state == PRAB_PER);
  assign cpu_ready = (state == PRAB_DONE);
  assign cpu_stall = (state != PRAB_IDLE) && (state != PRAB_DONE);

  sequence s_taken;
    state == PRAB_IDLE && cpu_req && !dtc_busy;
  endsequence

  sequence s_finish;
    acked ##1 cpu_ready;
  endsequence

  a_total_count: assert property (@(posedge clk) disable iff (!resetn)
    cpu_ready |-> acc_cycles == elapsed)
    else $error("reported access cycles differ from elapsed cycles");

  a_nosync_direct: assert property (@(posedge clk) disable iff (!resetn)
    state == PRAB_MAIN && !need_sync |=> per_req)
    else $error("unsynchronised bus access was delayed");

  a_sync_on_tick: assert property (@(posedge clk) disable iff (!resetn)
    per_req && $past(state) == PRAB_SYNC |-> $past(tick))
    else $error("synchronised strobe not on a peripheral boundary");

  a_sync_one_pclk: assert property (@(posedge clk) disable iff (!resetn)
    per_req |-> sync_cnt <= SYNC_W'(pclk_ratio))
    else $error("main plus sync cycles exceeded one peripheral clock");

  a_next_access: assert property (@(posedge clk) disable iff (!resetn)
    cpu_ready ##1 s_taken |=> state == PRAB_MAIN)
    else $error("follow-on access not started right after completion");

  a_dtc_hold: assert property (@(posedge clk) disable iff (!resetn)
    state == PRAB_IDLE && dtc_busy |=> state == PRAB_IDLE)
    else $error("access started while transfer controller busy");

  // Stall may only drop on the edge that takes the peripheral completion
  a_stall_until: assert property (@(posedge clk) disable iff (!resetn)
    cpu_stall && !acked |=> cpu_stall)
    else $error("stall dropped before peripheral completion");

  a_ready_after_ack: assert property (@(posedge clk) disable iff (!resetn)
    cpu_ready |-> $past(acked))
    else $error("ready without peripheral completion");

  a_finish_bound: assert property (@(posedge clk) disable iff (!resetn)
    acked |-> s_finish)
    else $error("ready not given one cycle after peripheral completion");

  a_read_data: assert property (@(posedge clk) disable iff (!resetn)
    acked && !per_we |=> cpu_rdata == $past(per_rdata))
    else $error("read data not returned from peripheral");

  a_strobe_once: assert property (@(posedge clk) disable iff (!resetn)
    per_req |=> !per_req)
    else $error("peripheral strobe held for more than one cycle");

  a_req_latched: assert property (@(posedge clk) disable iff (!resetn)
    cpu_stall |=> $stable(per_addr) && $stable(per_we) && $stable(per_wdata))
    else $error("latched request changed during an access");

  a_sync_needed: assert property (@(posedge clk) disable iff (!resetn)
    state == PRAB_SYNC |-> need_sync)
    else $error("sync cycle inserted for a bus that needs none");

  a_done_release: assert property (@(posedge clk) disable iff (!resetn)
    cpu_ready |=> state == PRAB_IDLE && !cpu_stall)
    else $error("bridge not free on the cycle after completion");
endmodule

// file: dv/prab_per_model.sv
// Peripheral register block model answering the bridge strobe
`timescale 1ns/10ps
module prab_per_model
  import prab_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic [3:0] dly, // Wait cycles before ack
  input wire logic per_req, // Strobe from bridge
  input wire logic [ADDR_W-1:0] per_addr, // Register address
  output logic per_ack, // Access done
  output logic [DATA_W-1:0] per_rdata // Read data
);
  logic [3:0] cnt;
  logic junk;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
      if (per_req) cnt <= dly;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
  assign per_ack = (per_req && dly == 4'h0) || cnt == 4'h1;
  // Toggle outside ack so stale data can never pass for a reply
  assign per_rdata = per_ack ? {8'h00, per_addr} ^ 32'h5a000000 : {DATA_W{junk}};
endmodule

// file: dv/test_peripheral_register_access_bridge.sv
// Self-checking bench for the peripheral register access bridge
`timescale 1ns/10ps
module test_peripheral_register_access_bridge
  import prab_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic cpu_berr_reg = 1'b0;
  logic dtc_busy = 1'b0;
  logic [RATIO_W-1:0] pclk_ratio = 3'h3;
  logic [ADDR_W-1:0] cpu_addr = 24'h000000;
  logic [DATA_W-1:0] cpu_wdata = 32'h00000000;
  logic [BUS_W-1:0] cpu_bus = BUS_P1;
  logic [3:0] dly = 4'h0;
  logic cpu_ready, cpu_stall, per_req, per_we, per_ack;
  logic [DATA_W-1:0] cpu_rdata, per_wdata, per_rdata;
  logic [CNT_W-1:0] acc_cycles;
  logic [ADDR_W-1:0] per_addr;
  logic [BUS_W-1:0] per_bus;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int s, lo, hi;
  prab_bridge i_prab_bridge (.clk(clk), .resetn(resetn), .pclk_ratio(pclk_ratio),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_bus(cpu_bus), .cpu_berr_reg(cpu_berr_reg), .dtc_busy(dtc_busy),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .cpu_stall(cpu_stall),
    .acc_cycles(acc_cycles), .per_req(per_req), .per_we(per_we), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_bus(per_bus), .per_ack(per_ack), .per_rdata(per_rdata));
  prab_per_model i_prab_per_model (.clk(clk), .resetn(resetn), .dly(dly),
    .per_req(per_req), .per_addr(per_addr), .per_ack(per_ack), .per_rdata(per_rdata));
  always #5 clk = ~clk;
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Returns the sync cycles seen; ew is the expected gap to acceptance, 0 skips it
  task automatic access(input logic [BUS_W-1:0] b, input logic w, input logic [ADDR_W-1:0] a,
      input logic e, input logic [3:0] d, input int ew, output int sc);
    int n;
    int k;
    int seen;
    n = 1;
    k = 0;
    seen = 0;
    cpu_bus = b;
    cpu_we = w;
    cpu_addr = a;
    cpu_berr_reg = e;
    dly = d;
    cpu_wdata = {a, 8'h3c};
    cpu_req = 1'b1;
    while (cpu_stall !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (ew != 0) chk(k, ew);
    cpu_req = 1'b0;
    while (cpu_ready !== 1'b1 && n < 40) begin
      chk(cpu_stall, 1'b1);
      if (per_req === 1'b1) seen++;
      if (per_req === 1'b1) chk({per_we, per_bus, per_addr}, {w, b, a});
      if (per_req === 1'b1 && w) chk(per_wdata, {a, 8'h3c});
      @(negedge clk);
      n++;
    end
    chk(seen, 1);
    // n also counts the ready cycle, which is not part of the access
    chk(acc_cycles, n - 1);
    if (!w) chk(cpu_rdata, {8'h00, a} ^ 32'h5a000000);
    else chk(cpu_rdata, 32'h0);
    sc = n - 3 - d;
  endtask
  // Stepping the delay shifts each access against the peripheral phase
  task automatic t_sync(input logic [BUS_W-1:0] b);
    lo = 99;
    hi = -1;
    for (int i = 0; i < 6; i++) begin
      access(b, i[0], 24'h00b300 + 24'((i + 1) / 2), 1'b0, 4'(i % 3), (i == 0) ? 0 : 2, s);
      chk(32'(s >= 0 && s <= 3), 32'h1);
      if (s < lo) lo = s;
      if (s > hi) hi = s;
    end
    chk(32'(hi > lo), 32'h1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    chk({cpu_ready, cpu_stall, per_req, acc_cycles}, 32'h0);
    resetn = 1'b1;
    access(BUS_P1, 1'b1, 24'h00c000, 1'b0, 4'h0, 1, s);
    chk(s, 0);
    access(BUS_EXT, 1'b0, 24'h00c001, 1'b1, 4'h2, 2, s);
    chk(s, 0);
    for (int b = 2; b < 8; b++) begin
      if (b != 3) t_sync(3'(b));
    end
    dtc_busy = 1'b1;
    cpu_req = 1'b1;
    repeat (4) @(negedge clk);
    chk(cpu_stall, 1'b0);
    dtc_busy = 1'b0;
    access(BUS_P1, 1'b0, 24'h00c020, 1'b0, 4'h1, 1, s);
    chk(s, 0);
    pclk_ratio = 3'h0; // Clock setup changed only while idle, never mid-access
    access(BUS_P5, 1'b1, 24'h00b082, 1'b0, 4'h0, 2, s);
    chk(s, 0);
    give_verdict();
  end
endmodule
